// File: fwps_params.svh
// Purpose: Offsets, field positions, reset values and key codes of the word program sequencer.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes:   Definitions only.
`ifndef FWPS_PARAMS_SVH
`define FWPS_PARAMS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define FWPS_OFS_CTRL      12'h000
`define FWPS_OFS_KEY       12'h004
`define FWPS_OFS_PAGE      12'h008
`define FWPS_OFS_TBLWT_LO  12'h00c
`define FWPS_OFS_TBLWT_HI  12'h010
`define FWPS_OFS_LATCH     12'h014

// ************************************************************
// Control fields
// ************************************************************
`define FWPS_CTRL_LAUNCH   15
`define FWPS_CTRL_WREN     14
`define FWPS_CTRL_BUSY_ERR 13
`define FWPS_OP_MSB        3
`define FWPS_OP_WORD       4'h3
`define FWPS_CTRL_RESET    16'h0000

// ************************************************************
// Unlock keys and widths
// ************************************************************
`define FWPS_KEY_FIRST     8'h55
`define FWPS_KEY_SECOND    8'haa
`define FWPS_PAGE_W        8
`define FWPS_OFFSET_W      16
`define FWPS_WORD_W        24

`endif

// File: fwps_pkg.sv
// Purpose: Types shared by the word program sequencer.
// Assumes: Constants come from fwps_params.svh.
// Notes:   Nothing here is imported; users write fwps_pkg::name.
`include "fwps_params.svh"

package fwps_pkg;

   typedef enum logic [1:0] {
      FWPS_IDLE = 2'b00,
      FWPS_PROG = 2'b01,
      FWPS_WAIT = 2'b10
   } fwps_state_t;

   typedef enum logic [1:0] {
      FWPS_KEY_NONE  = 2'b00,
      FWPS_KEY_HALF  = 2'b01,
      FWPS_KEY_ARMED = 2'b10
   } fwps_key_t;

   typedef struct packed {
      logic [`FWPS_WORD_W-1:0] addr;
      logic [`FWPS_WORD_W-1:0] data;
   } fwps_flash_req_t;

endpackage : fwps_pkg

// File: fwps_sequencer.sv
// Purpose: Programs one 24-bit word into erased flash after an unlock key sequence and a launch bit set.
// Assumes: APB slave on pclk; the flash array raises flash_done for one cycle when a word is written.
// Notes:   Every access is answered with one wait state so that prdata and pready come from flops.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/100ps
`include "fwps_params.svh"

module fwps_sequencer (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [11:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   output logic                              flash_req,
   output fwps_pkg::fwps_flash_req_t         flash_word,
   input  wire logic                         flash_done
);

   // ************************************************************
   // Declarations
   // ************************************************************
   logic                            pready_q;
   logic [31:0]                     prdata_q;
   logic                            pslverr_q;
   logic [15:0]                     ctrl_q;
   logic [`FWPS_PAGE_W-1:0]         page_q;
   logic [`FWPS_OFFSET_W-1:0]       offset_q;
   logic [`FWPS_WORD_W-1:0]         latch_q;
   fwps_pkg::fwps_key_t             key_q;
   fwps_pkg::fwps_state_t           state_q;
   logic                            flash_req_q;
   fwps_pkg::fwps_flash_req_t       flash_word_q;
   logic                            acc;
   logic                            wr;
   logic                            launch_ok;
   logic                            busy;

   function automatic logic known_addr(input logic [11:0] a);
      known_addr = (a == `FWPS_OFS_CTRL) || (a == `FWPS_OFS_KEY) || (a == `FWPS_OFS_PAGE) ||
                   (a == `FWPS_OFS_TBLWT_LO) || (a == `FWPS_OFS_TBLWT_HI) || (a == `FWPS_OFS_LATCH);
   endfunction : known_addr

   // The access completes at the edge where pready is seen high, so every effect is tied to it.
   assign acc  = psel && penable && pready_q;
   assign wr   = acc && pwrite && known_addr(paddr);
   assign busy = (state_q != fwps_pkg::FWPS_IDLE);

   // Launch is taken only with the keys armed and the word-write pattern in the op field.
   assign launch_ok = wr && (paddr == `FWPS_OFS_CTRL) && pwdata[`FWPS_CTRL_LAUNCH] && !busy &&
                      (key_q == fwps_pkg::FWPS_KEY_ARMED) &&
                      (pwdata[`FWPS_OP_MSB:0] == `FWPS_OP_WORD);

   assign prdata     = prdata_q;
   assign pready     = pready_q;
   assign pslverr    = pslverr_q;
   assign flash_req  = flash_req_q;
   assign flash_word = flash_word_q;

   // ************************************************************
   // APB answer
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !known_addr(paddr);
         prdata_q  <= 32'h0000_0000;
         if (psel && penable && !pready_q && !pwrite) begin
            case (paddr)
               `FWPS_OFS_CTRL:     prdata_q <= {16'h0000, ctrl_q};
               `FWPS_OFS_PAGE:     prdata_q <= {24'h00_0000, page_q};
               `FWPS_OFS_TBLWT_LO: prdata_q <= {offset_q, latch_q[15:0]};
               `FWPS_OFS_TBLWT_HI: prdata_q <= {offset_q, 8'h00, latch_q[23:16]};
               `FWPS_OFS_LATCH:    prdata_q <= {8'h00, latch_q};
               default:            prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ************************************************************
   // Page, offset and write latch
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_q   <= 8'h00;
         offset_q <= 16'h0000;
         latch_q  <= 24'h00_0000;
      end else if (wr && !busy) begin
         // Loads are refused during a cycle so the word in flight cannot change underneath it.
         if (paddr == `FWPS_OFS_PAGE) begin
            page_q <= pwdata[`FWPS_PAGE_W-1:0];
         end
         if (paddr == `FWPS_OFS_TBLWT_LO) begin
            latch_q[15:0] <= pwdata[15:0];
            offset_q      <= pwdata[31:16];
         end
         if (paddr == `FWPS_OFS_TBLWT_HI) begin
            latch_q[23:16] <= pwdata[7:0];
            offset_q       <= pwdata[31:16];
         end
      end
   end

   // ************************************************************
   // Unlock key tracking
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_q <= fwps_pkg::FWPS_KEY_NONE;
      end else if (wr) begin
         // Any other write to a mapped register between the keys and the launch breaks the sequence.
         if (paddr == `FWPS_OFS_KEY && pwdata[7:0] == `FWPS_KEY_FIRST) begin
            key_q <= fwps_pkg::FWPS_KEY_HALF;
         end else if (paddr == `FWPS_OFS_KEY && pwdata[7:0] == `FWPS_KEY_SECOND &&
                      key_q == fwps_pkg::FWPS_KEY_HALF) begin
            key_q <= fwps_pkg::FWPS_KEY_ARMED;
         end else begin
            key_q <= fwps_pkg::FWPS_KEY_NONE;
         end
      end
   end

   // ************************************************************
   // Control register
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `FWPS_CTRL_RESET;
      end else begin
         if (state_q == fwps_pkg::FWPS_WAIT && flash_done) begin
            ctrl_q[`FWPS_CTRL_LAUNCH] <= 1'b0;
         end
         if (wr && paddr == `FWPS_OFS_CTRL) begin
            if (busy) begin
               // A write while busy is dropped and flagged; the flag clears on the next accepted control write.
               ctrl_q[`FWPS_CTRL_BUSY_ERR] <= 1'b1;
            end else begin
               ctrl_q[`FWPS_CTRL_WREN]      <= pwdata[`FWPS_CTRL_WREN];
               ctrl_q[`FWPS_CTRL_BUSY_ERR]  <= 1'b0;
               ctrl_q[`FWPS_OP_MSB:0]       <= pwdata[`FWPS_OP_MSB:0];
               ctrl_q[`FWPS_CTRL_LAUNCH]    <= launch_ok;
            end
         end
      end
   end

   // ************************************************************
   // Program sequencer
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= fwps_pkg::FWPS_IDLE;
      end else begin
         case (state_q)
            fwps_pkg::FWPS_IDLE: begin
               if (launch_ok) begin
                  state_q <= fwps_pkg::FWPS_PROG;
               end
            end
            fwps_pkg::FWPS_PROG: begin
               state_q <= fwps_pkg::FWPS_WAIT;
            end
            fwps_pkg::FWPS_WAIT: begin
               if (flash_done) begin
                  state_q <= fwps_pkg::FWPS_IDLE;
               end
            end
            default: begin
               state_q <= fwps_pkg::FWPS_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Flash request
   // ************************************************************
   // Request and word load at the same edge, so the array never sees a request with a stale word.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_req_q <= 1'b0;
      end else if (state_q == fwps_pkg::FWPS_PROG) begin
         flash_req_q <= 1'b1;
      end else if (state_q == fwps_pkg::FWPS_WAIT && !flash_done) begin
         flash_req_q <= 1'b1;
      end else begin
         // A done pulse, or any state outside the cycle, ends the request.
         flash_req_q <= 1'b0;
      end
   end

   // ************************************************************
   // Flash word
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_word_q <= '0;
      end else if (state_q == fwps_pkg::FWPS_PROG) begin
         // Copied once per cycle; loads are refused while busy, so the copy cannot drift.
         flash_word_q.addr <= {page_q, offset_q};
         flash_word_q.data <= latch_q;
      end
   end

endmodule : fwps_sequencer

// File: fwps_checker.sv
// Purpose: Port-level checks of the word program sequencer.
// Assumes: Only the top module's ports are visible.
// Notes:   Bound to the design at the foot of this file.
`timescale 1ns/100ps
`include "fwps_params.svh"
module fwps_checker (
   input wire logic                      pclk,
   input wire logic                      presetn,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [11:0]               paddr,
   input wire logic [31:0]               pwdata,
   input wire logic [31:0]               prdata,
   input wire logic                      pready,
   input wire logic                      pslverr,
   input wire logic                      flash_req,
   input wire fwps_pkg::fwps_flash_req_t flash_word,
   input wire logic                      flash_done
);
   // ****
   // Helper logic
   // ****
   logic [1:0] key_q;
   wire        acc    = psel & penable & pready & pwrite & !pslverr;
   wire        launch = acc & (paddr == `FWPS_OFS_CTRL) & pwdata[`FWPS_CTRL_LAUNCH];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Any accepted write that is not the next key breaks the pair.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         key_q <= 2'b00;
      else if (acc)
         key_q <= {key_q[0] & (paddr == `FWPS_OFS_KEY) & (pwdata[7:0] == `FWPS_KEY_SECOND),
                   (paddr == `FWPS_OFS_KEY) & (pwdata[7:0] == `FWPS_KEY_FIRST)};
   end
   // ****
   // Properties
   // ****
   property p_one_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("access not answered after one wait");
   property p_err;
      psel && penable && pready && paddr > `FWPS_OFS_LATCH |-> pslverr && (pwrite || prdata == 32'h0);
   endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_done_clr;
      flash_req && flash_done |=> !flash_req;
   endproperty
   a_done_clr: assert property (p_done_clr) else $error("request held after done");
   property p_word_hold;
      flash_req && !flash_done |=> $stable(flash_word);
   endproperty
   a_word_hold: assert property (p_word_hold) else $error("word changed while busy");
   property p_go;
      launch && key_q[1] && pwdata[3:0] == `FWPS_OP_WORD && !flash_req |-> ##[1:3] flash_req;
   endproperty
   a_go: assert property (p_go) else $error("valid launch did not start");
   property p_bad_op;
      launch && pwdata[3:0] != `FWPS_OP_WORD && !flash_req |=> (!flash_req) [*4];
   endproperty
   a_bad_op: assert property (p_bad_op) else $error("launch with other op started");
   property p_no_key;
      launch && !key_q[1] && !flash_req |=> !flash_req ##1 !flash_req ##1 !flash_req;
   endproperty
   a_no_key: assert property (p_no_key) else $error("launch without keys started");
   property p_cause;
      $rose(flash_req) |-> $past(launch, 2) || $past(launch, 3);
   endproperty
   a_cause: assert property (p_cause) else $error("request without launch");
endmodule : fwps_checker

bind fwps_sequencer fwps_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .flash_req(flash_req), .flash_word(flash_word), .flash_done(flash_done));

// File: flash_word_program_sequencer_tb.sv
// Purpose: Self-checking bench of the word program sequencer.
// Assumes: APB answers after one wait state; flash done is a one-cycle pulse.
// Notes:   Ops 0..15 are all launched, then key order faults.
`timescale 1ns/100ps
`include "fwps_params.svh"
module flash_word_program_sequencer_tb;
   logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, flash_req, flash_done, er, go;
   logic [11:0]               paddr;
   logic [31:0]               pwdata, prdata, rd;
   logic [7:0]                page, hi;
   logic [15:0]               off, lo;
   logic [3:0]                op;
   fwps_pkg::fwps_flash_req_t flash_word;
   int                        n_fail = 0, checked = 0, dly = 0, n, km;
   fwps_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flash_req(flash_req), .flash_word(flash_word), .flash_done(flash_done));
   initial pclk = 1'b0;
   always #20 pclk = ~pclk;
   // Flash array stand-in: every target word counts as erased, and each takes six to nine extra cycles,
   // so that a status read and a refused control write both land while the word is still in flight.
   always @(posedge pclk) begin
      if (flash_req && !flash_done && dly == 0)
         flash_done <= 1'b1;
      else if (flash_req && !flash_done)
         dly <= dly - 1;
      else begin
         flash_done <= 1'b0;
         dly <= $urandom_range(9, 6);
      end
   end
   function automatic logic expect_go(input logic [3:0] o, input int k);
      return o == `FWPS_OP_WORD && k == 0;
   endfunction : expect_go
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   // Ready is sampled at the rising edge that completes the access; data are taken and the request
   // released at that same edge. Only the watchdog ends a wait that never completes.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   initial begin
      {psel, penable, pwrite, presetn, paddr, pwdata} = '0;
      void'($urandom(32'h75346129));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `FWPS_OFS_CTRL, 32'h0, rd, er);
      chk(rd, `FWPS_CTRL_RESET);
      apb(1'b0, 12'h018, 32'h0, rd, er);
      chk({er, rd}, {1'b1, 32'h0});
      $display("test reset done");
      for (int i = 0; i < 20; i++) begin
         op = (i < 16) ? i[3:0] : `FWPS_OP_WORD;
         km = (i < 16) ? 0 : i - 16;
         {page, off, lo, hi} = 48'({$urandom(), $urandom()});
         wr(`FWPS_OFS_PAGE, {24'h0, page});
         wr(`FWPS_OFS_TBLWT_LO, {off, lo});
         wr(`FWPS_OFS_TBLWT_HI, {off, 8'h0, hi});
         wr(`FWPS_OFS_CTRL, {16'h0, 12'h400, op});
         case (km)
            0: begin wr(`FWPS_OFS_KEY, 32'h55); wr(`FWPS_OFS_KEY, 32'haa); end
            1: begin wr(`FWPS_OFS_KEY, 32'haa); wr(`FWPS_OFS_KEY, 32'h55); end
            2: begin wr(`FWPS_OFS_KEY, 32'h55); wr(`FWPS_OFS_PAGE, {24'h0, page}); wr(`FWPS_OFS_KEY, 32'haa); end
            default: wr(`FWPS_OFS_KEY, 32'haa);
         endcase
         wr(`FWPS_OFS_CTRL, {16'h0, 12'hc00, op});
         go = expect_go(op, km);
         n = 0;
         while (flash_req !== 1'b1 && n < 8) begin // Bus idle after launch.
            @(negedge pclk);
            n++;
         end
         chk(flash_req, go);
         if (go)
            chk(flash_word, {page, off, hi, lo});
         apb(1'b0, `FWPS_OFS_CTRL, 32'h0, rd, er);
         chk(rd, {16'h0, go, 1'b1, 10'h0, op});
         // A control write while the word is in flight must be dropped and flagged.
         if (go)
            wr(`FWPS_OFS_CTRL, 32'h0);
         n = 0;
         do begin
            apb(1'b0, `FWPS_OFS_CTRL, 32'h0, rd, er);
            n++;
         end while (rd[15] !== 1'b0 && n < 20);
         chk(rd, {16'h0, 1'b0, 1'b1, go, 9'h0, op});
         apb(1'b0, `FWPS_OFS_LATCH, 32'h0, rd, er);
         chk(rd, {8'h0, hi, lo});
         apb(1'b0, `FWPS_OFS_TBLWT_LO, 32'h0, rd, er);
         chk(rd, {off, lo});
         $display("test %0d done", i);
      end
      stop_test();
   end
   initial begin
      repeat (30000) @(posedge pclk);
      n_fail++;
      stop_test();
   end
endmodule : flash_word_program_sequencer_tb
